/* File: pbm_pkg.sv */
// shared constants and types for the port b upper-line function mux
package pbm_pkg;

  // number of muxed lines; index 0 is port_b_line_26, index 5 is port_b_line_31
  localparam int PB_LINES = 6;
  localparam int LN26 = 0;
  localparam int LN27 = 1;
  localparam int LN28 = 2;
  localparam int LN29 = 3;
  localparam int LN30 = 4;
  localparam int LN31 = 5;

  // width of one line's function select field
  localparam int SEL_W = 2;

  // pin state from reset: nothing driven, output data low
  localparam logic [PB_LINES-1:0] PIN_OUT_RST = 6'h00;
  localparam logic [PB_LINES-1:0] PIN_OE_N_RST = 6'h3f;

  // idle level of active-low modem lines (rts, cts)
  localparam logic MODEM_IDLE = 1'b1;

  // function selected on one line
  typedef enum logic [1:0] {
    FN_GPIO = 2'h0,
    FN_FCC = 2'h1,
    FN_SCC = 2'h2,
    FN_TDM = 2'h3
  } pbm_fn_e;

  // send-request handshake of the fast controller
  typedef enum logic [1:0] {
    RTS_IDLE = 2'h0,
    RTS_REQ = 2'h1,
    RTS_GRANT = 2'h2
  } pbm_rts_e;

  // fast controller mii transmit side
  typedef struct packed {
    logic tx_er;
    logic tx_en;
  } pbm_fcc_tx_s;

  // fast controller mii receive side
  typedef struct packed {
    logic rx_dv;
    logic rx_er;
    logic col;
    logic crs;
  } pbm_fcc_rx_s;

  // tdm channel b two receive side
  typedef struct packed {
    logic rxd;
    logic rsync;
    logic tsync;
  } pbm_tdm_rx_s;

endpackage : pbm_pkg

/* File: pbm_port_b_upper_mux.sv */
// pin function mux for port b lines 31 down to 26
`timescale 1ns/10ps
`default_nettype none

module pbm_port_b_upper_mux
  import pbm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // per-line function select, two bits per line, line 26 in the low bits
  input wire logic [SEL_W*PB_LINES-1:0] line_sel_i,
  // fast controller: 1 selects mii, 0 selects hdlc serial, nibble or transparent
  input wire logic fcc_mii_mode_i,
  // serial controller two: 1 selects ethernet mode
  input wire logic scc_eth_mode_i,
  // pins, split into input, output and active-low output enable
  input wire logic [PB_LINES-1:0] pin_in_i,
  output logic [PB_LINES-1:0] pin_out_o,
  output logic [PB_LINES-1:0] pin_oe_n_o,
  // clear-to-send pin of the fast controller, active low, asynchronous
  input wire logic fcc_cts_n_pin_i,
  // general-purpose side
  input wire logic [PB_LINES-1:0] gpio_out_i,
  input wire logic [PB_LINES-1:0] gpio_dir_i,
  output logic [PB_LINES-1:0] gpio_in_o,
  // fast controller side
  input wire pbm_fcc_tx_s fcc_tx_i,
  input wire logic fcc_rts_req_i,
  output pbm_fcc_rx_s fcc_rx_o,
  output logic fcc_broken_hdr_o,
  output logic fcc_rts_granted_o,
  // serial controller two side
  input wire logic scc_txd_i,
  input wire logic scc_rts_req_i,
  input wire logic scc_eth_tx_en_i,
  output logic scc_rxd_o,
  // serial interface two side
  input wire logic tdm_b2_txd_i,
  input wire logic tdm_c2_txd_i,
  output pbm_tdm_rx_s tdm_b2_rx_o
);

  // two-stage synchronisers for every pin input and for cts
  logic [PB_LINES-1:0] pin_meta_q;
  logic [PB_LINES-1:0] pin_sync_q;
  logic cts_meta_q;
  logic cts_sync_q;

  // registered pin drive
  logic [PB_LINES-1:0] pin_out_q;
  logic [PB_LINES-1:0] pin_oe_n_q;

  // registered peripheral-side inputs
  pbm_fcc_rx_s fcc_rx_q;
  pbm_tdm_rx_s tdm_rx_q;
  logic scc_rxd_q;
  logic [PB_LINES-1:0] gpio_in_q;
  logic broken_hdr_q;

  // send-request handshake state
  pbm_rts_e rts_q;
  pbm_rts_e rts_d;

  // decoded selects
  pbm_fn_e sel_w [PB_LINES];
  logic [PB_LINES-1:0] is_gpio_w;
  logic [PB_LINES-1:0] is_fcc_w;
  logic [PB_LINES-1:0] is_scc_w;
  logic [PB_LINES-1:0] is_tdm_w;

  // per-line next drive value and drive enable (1 = drive)
  logic [PB_LINES-1:0] dout_w;
  logic [PB_LINES-1:0] drv_w;

  // next peripheral-side inputs
  pbm_fcc_rx_s fcc_rx_w;
  pbm_tdm_rx_s tdm_rx_w;
  logic scc_rxd_w;
  logic [PB_LINES-1:0] gpio_in_w;
  logic broken_hdr_w;

  // line 28 modes of the fast and serial controllers
  logic fcc_rts_mode_w;
  logic fcc_rts_n_w;
  logic scc_line28_w;

  // one select decoder per line
  genvar k;
  generate
    for (k = 0; k < PB_LINES; k++) begin : g_sel
      assign sel_w[k] = pbm_fn_e'(line_sel_i[SEL_W*k +: SEL_W]);
      assign is_gpio_w[k] = (sel_w[k] == FN_GPIO);
      assign is_fcc_w[k] = (sel_w[k] == FN_FCC);
      assign is_scc_w[k] = (sel_w[k] == FN_SCC);
      assign is_tdm_w[k] = (sel_w[k] == FN_TDM);
      // general-purpose input reads the line only while it owns it
      // (a line lent to a peripheral reads 0, so its traffic never leaks here)
      assign gpio_in_w[k] = is_gpio_w[k] & pin_sync_q[k];
    end
  endgenerate

  // line 28 ownership inside the fast controller depends on its protocol
  assign fcc_rts_mode_w = is_fcc_w[LN28] & ~fcc_mii_mode_i;
  // rts unaligned: follows the handshake state, no bit-clock gating
  assign fcc_rts_n_w = (rts_q == RTS_IDLE);
  // scc rts low, transmit enable in ethernet mode
  // the serial controller has no cts handshake here, so its rts simply mirrors
  // the request; a partner that needs a grant must be watched by that controller
  assign scc_line28_w = scc_eth_mode_i ? scc_eth_tx_en_i : ~scc_rts_req_i;

  // line 31 drive
  // a fast controller selected here outside mii mode has no output on this
  // line, so the pin is left floating rather than driven with stale data
  // mii tx error, b2 transmit data, scc input leaves it undriven
  assign drv_w[LN31] = is_gpio_w[LN31] ? gpio_dir_i[LN31] :
                       ((is_fcc_w[LN31] & fcc_mii_mode_i) | is_tdm_w[LN31]);
  assign dout_w[LN31] = is_gpio_w[LN31] ? gpio_out_i[LN31] :
                        is_fcc_w[LN31] ? fcc_tx_i.tx_er :
                        is_tdm_w[LN31] ? tdm_b2_txd_i : 1'b0;

  // line 30 drive
  // only the serial controller transmits here; the other two owners listen
  // scc transmit data; rx_dv and b2 receive data are inputs
  assign drv_w[LN30] = is_gpio_w[LN30] ? gpio_dir_i[LN30] : is_scc_w[LN30];
  assign dout_w[LN30] = is_gpio_w[LN30] ? gpio_out_i[LN30] :
                        is_scc_w[LN30] ? scc_txd_i : 1'b0;

  // line 29 drive
  // tx enable in mii mode; b2 receive sync is an input
  assign drv_w[LN29] = is_gpio_w[LN29] ? gpio_dir_i[LN29] :
                       (is_fcc_w[LN29] & fcc_mii_mode_i);
  assign dout_w[LN29] = is_gpio_w[LN29] ? gpio_out_i[LN29] :
                        is_fcc_w[LN29] ? fcc_tx_i.tx_en : 1'b0;

  // line 28 drive: fcc rts outside mii, scc rts or transmit enable, else input
  // line 28 has the most owners of the six; the select alone decides which one
  // drives, so a mode change never puts two drivers on the pin
  // fcc rts low
  assign drv_w[LN28] = is_gpio_w[LN28] ? gpio_dir_i[LN28] :
                       (fcc_rts_mode_w | is_scc_w[LN28]);
  assign dout_w[LN28] = is_gpio_w[LN28] ? gpio_out_i[LN28] :
                        fcc_rts_mode_w ? fcc_rts_n_w :
                        is_scc_w[LN28] ? scc_line28_w : 1'b0;

  // line 27 drive
  // c2 transmit data; collision is an input
  assign drv_w[LN27] = is_gpio_w[LN27] ? gpio_dir_i[LN27] : is_tdm_w[LN27];
  assign dout_w[LN27] = is_gpio_w[LN27] ? gpio_out_i[LN27] :
                        is_tdm_w[LN27] ? tdm_c2_txd_i : 1'b0;

  // line 26 drive: only the general-purpose function ever drives it
  // carrier sense is its only peripheral use, and that is an input
  assign drv_w[LN26] = is_gpio_w[LN26] & gpio_dir_i[LN26];
  assign dout_w[LN26] = is_gpio_w[LN26] & gpio_out_i[LN26];

  // fast controller receive side, gated so an unowned line reads inactive
  // gating also hides the pins while the controller runs hdlc, where these
  // lines mean something else and would fake a collision or a carrier
  // rx data valid
  assign fcc_rx_w.rx_dv = is_fcc_w[LN30] & fcc_mii_mode_i & pin_sync_q[LN30];
  // rx error only in mii mode
  assign fcc_rx_w.rx_er = is_fcc_w[LN28] & fcc_mii_mode_i & pin_sync_q[LN28];
  assign fcc_rx_w.col = is_fcc_w[LN27] & fcc_mii_mode_i & pin_sync_q[LN27];
  assign fcc_rx_w.crs = is_fcc_w[LN26] & fcc_mii_mode_i & pin_sync_q[LN26];

  // broken header: carrier present while data is not valid
  // built from the gated bits so it can only rise in mii mode; it carries the
  // same three-cycle latency as the receive bits it is made from
  assign broken_hdr_w = fcc_rx_w.crs & ~fcc_rx_w.rx_dv;

  assign scc_rxd_w = is_scc_w[LN31] & pin_sync_q[LN31];

  assign tdm_rx_w.rxd = is_tdm_w[LN30] & pin_sync_q[LN30];
  // the sync inputs are only passed on here; framing belongs to the channel,
  // and a sync pulse shorter than one clock period can be missed
  // b2 receive sync
  assign tdm_rx_w.rsync = is_tdm_w[LN29] & pin_sync_q[LN29];
  assign tdm_rx_w.tsync = is_tdm_w[LN28] & pin_sync_q[LN28];

  // send-request handshake: a request is only granted once cts reads low
  // the grant follows the synchronised cts, so it lags the pin by three edges;
  // dropping the request or leaving hdlc mode returns to idle at the next edge
  always_comb begin
    rts_d = rts_q;
    case (rts_q)
      RTS_IDLE: begin
        if (fcc_rts_req_i && fcc_rts_mode_w) begin
          rts_d = RTS_REQ;
        end
      end
      RTS_REQ: begin
        if (!fcc_rts_req_i || !fcc_rts_mode_w) begin
          rts_d = RTS_IDLE;
        end else if (cts_sync_q != MODEM_IDLE) begin
          rts_d = RTS_GRANT;
        end
      end
      // cts going back high withdraws the grant but keeps the request
      RTS_GRANT: begin
        if (!fcc_rts_req_i || !fcc_rts_mode_w) begin
          rts_d = RTS_IDLE;
        end else if (cts_sync_q == MODEM_IDLE) begin
          rts_d = RTS_REQ;
        end
      end
      default: begin
        rts_d = RTS_IDLE;
      end
    endcase
  end

  // input synchronisers; first stage feeds only the second
  // pins and cts arrive from outside the clock domain; two flops trade two
  // cycles of latency for a settled level before any decode sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      cts_meta_q <= MODEM_IDLE;
      cts_sync_q <= MODEM_IDLE;
    end else begin
      pin_meta_q <= pin_in_i;
      pin_sync_q <= pin_meta_q;
      cts_meta_q <= fcc_cts_n_pin_i;
      cts_sync_q <= cts_meta_q;
    end
  end

  // one owner per line: registered drive, released pins stay undriven
  // registering the drive keeps a select change from glitching a pin, at the
  // price of one cycle before the new owner appears on it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_q <= PIN_OUT_RST;
      pin_oe_n_q <= PIN_OE_N_RST;
    end else begin
      pin_out_q <= dout_w;
      pin_oe_n_q <= ~drv_w;
    end
  end

  // registered peripheral-side inputs and handshake state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcc_rx_q <= '0;
      tdm_rx_q <= '0;
      scc_rxd_q <= 1'b0;
      gpio_in_q <= '0;
      broken_hdr_q <= 1'b0;
      rts_q <= RTS_IDLE;
    end else begin
      fcc_rx_q <= fcc_rx_w;
      tdm_rx_q <= tdm_rx_w;
      scc_rxd_q <= scc_rxd_w;
      gpio_in_q <= gpio_in_w;
      broken_hdr_q <= broken_hdr_w;
      rts_q <= rts_d;
    end
  end

  // outputs
  // every data output comes straight from a flop; only the grant flag is
  // decoded, and it decodes a single state register so it cannot glitch
  assign pin_out_o = pin_out_q;
  assign pin_oe_n_o = pin_oe_n_q;
  assign fcc_rx_o = fcc_rx_q;
  assign fcc_broken_hdr_o = broken_hdr_q;
  assign fcc_rts_granted_o = (rts_q == RTS_GRANT);
  assign scc_rxd_o = scc_rxd_q;
  assign tdm_b2_rx_o = tdm_rx_q;
  assign gpio_in_o = gpio_in_q;

endmodule : pbm_port_b_upper_mux

`default_nettype wire

/* File: pbm_port_b_upper_mux_properties.sv */
// concurrent checks on the port b upper-line function mux
`timescale 1ns/10ps
`default_nettype none
module pbm_port_b_upper_mux_properties
  import pbm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SEL_W*PB_LINES-1:0] line_sel_i,
  input wire logic fcc_mii_mode_i,
  input wire logic scc_eth_mode_i,
  input wire logic [PB_LINES-1:0] pin_in_i,
  input wire logic [PB_LINES-1:0] pin_out_o,
  input wire logic [PB_LINES-1:0] pin_oe_n_o,
  input wire logic fcc_cts_n_pin_i,
  input wire pbm_fcc_tx_s fcc_tx_i,
  input wire logic fcc_rts_req_i,
  input wire pbm_fcc_rx_s fcc_rx_o,
  input wire logic fcc_broken_hdr_o,
  input wire logic fcc_rts_granted_o,
  input wire logic scc_rts_req_i,
  input wire logic scc_eth_tx_en_i,
  input wire logic tdm_b2_txd_i,
  input wire logic tdm_c2_txd_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // per-line selects; line 29 needs none here
  wire logic [1:0] s26 = line_sel_i[1:0];
  wire logic [1:0] s27 = line_sel_i[3:2];
  wire logic [1:0] s28 = line_sel_i[5:4];
  wire logic [1:0] s30 = line_sel_i[9:8];
  wire logic [1:0] s31 = line_sel_i[11:10];
  wire logic fcc28 = s28 == FN_FCC && !fcc_mii_mode_i;

  a_tx_err_out: assert property (s31 == FN_FCC && fcc_mii_mode_i |=>
    !pin_oe_n_o[5] && pin_out_o[5] == $past(fcc_tx_i.tx_er)) else $error("tx error pin wrong");
  a_tdm_b_txd: assert property (s31 == FN_TDM |=>
    !pin_oe_n_o[5] && pin_out_o[5] == $past(tdm_b2_txd_i)) else $error("tdm b pin wrong");
  a_tdm_c_txd: assert property (s27 == FN_TDM |=>
    !pin_oe_n_o[1] && pin_out_o[1] == $past(tdm_c2_txd_i)) else $error("tdm c pin wrong");
  a_scc_tx_enable: assert property (s28 == FN_SCC && scc_eth_mode_i |=>
    pin_out_o[2] == $past(scc_eth_tx_en_i)) else $error("tx enable pin wrong");
  a_scc_rts_low: assert property (s28 == FN_SCC && !scc_eth_mode_i |=>
    pin_out_o[2] == !$past(scc_rts_req_i)) else $error("scc rts pin wrong");
  a_broken_hdr: assert property (fcc_broken_hdr_o ==
    (fcc_rx_o.crs && !fcc_rx_o.rx_dv)) else $error("broken header flag wrong");
  a_rx_valid_path: assert property ((s30 == FN_FCC && fcc_mii_mode_i) [*4] |->
    fcc_rx_o.rx_dv == $past(pin_in_i[4], 3)) else $error("rx valid path wrong");
  a_grant_cts: assert property (fcc_rts_granted_o |->
    !$past(fcc_cts_n_pin_i, 3) && $past(fcc_rts_req_i)) else $error("grant without cts");
  a_rts_drive: assert property ((fcc28 && fcc_rts_req_i) [*2] |=>
    !pin_out_o[2] && !pin_oe_n_o[2]) else $error("rts not driven low");
  a_line26_input: assert property (s26 != FN_GPIO |=>
    pin_oe_n_o[0]) else $error("line 26 driven");

  c_grant: cover property (fcc_rts_granted_o);
  c_broken: cover property (fcc_broken_hdr_o);
  c_tdm_out: cover property (s31 == FN_TDM && pin_out_o[5]);
endmodule : pbm_port_b_upper_mux_properties
bind pbm_port_b_upper_mux pbm_port_b_upper_mux_properties u_props (.*);
`default_nettype wire

/* File: pbm_far_model.sv */
// phy, modem and highway levels on the far side of the upper port b lines
`timescale 1ns/10ps
`default_nettype none
module pbm_far_model (
  input wire logic clk_i,
  input wire logic [5:0] pin_i,
  input wire logic [5:0] rx_i,
  input wire logic [3:0] cts_dly_i,
  output logic [5:0] drv_o,
  output logic cts_n_o
);
  logic [3:0] cnt_q;
  assign drv_o = rx_i;
  // cts answers a low rts after a set delay, so slow partners can be tried
  always_ff @(posedge clk_i) begin
    if (pin_i[2]) begin
      cnt_q <= 4'h0;
      cts_n_o <= 1'b1;
    end else if (cnt_q == cts_dly_i) cts_n_o <= 1'b0;
    else cnt_q <= cnt_q + 4'h1;
  end
endmodule : pbm_far_model
`default_nettype wire

/* File: tb_port_b_upper_pin_function_mux.sv */
// self-checking bench for the port b upper-line function mux
`timescale 1ns/10ps
`default_nettype none
module tb_port_b_upper_pin_function_mux
  import pbm_pkg::*;
;
  logic clk_i, rst_i, fcc_mii_mode_i, scc_eth_mode_i, fcc_cts_n_pin_i, fcc_rts_req_i;
  logic fcc_broken_hdr_o, fcc_rts_granted_o, scc_txd_i, scc_rts_req_i, scc_eth_tx_en_i;
  logic scc_rxd_o, tdm_b2_txd_i, tdm_c2_txd_i;
  logic [11:0] line_sel_i;
  logic [5:0] pin_in_i, pin_out_o, pin_oe_n_o, gpio_out_i, gpio_dir_i, gpio_in_o, rx_i, drv;
  logic [3:0] cts_dly_i;
  pbm_fcc_tx_s fcc_tx_i;
  pbm_fcc_rx_s fcc_rx_o;
  pbm_tdm_rx_s tdm_b2_rx_o;
  int num_errors = 0;
  int comparisons = 0;
  // wire level: the device wins where it drives, else the far side
  assign pin_in_i = (pin_oe_n_o & drv) | (~pin_oe_n_o & pin_out_o);
  pbm_port_b_upper_mux dut (.*);
  pbm_far_model u_far (.clk_i(clk_i), .pin_i(pin_in_i), .rx_i(rx_i),
    .cts_dly_i(cts_dly_i), .drv_o(drv), .cts_n_o(fcc_cts_n_pin_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask : step
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic t_mii_tx;
    line_sel_i = 12'h440;
    fcc_mii_mode_i = 1'b1;
    fcc_tx_i = 2'h3;
    step(2);
    check(pin_oe_n_o & 6'h28, 6'h00);
    check(pin_out_o & 6'h28, 6'h28);
    fcc_tx_i = 2'h1;
    step(2);
    check(pin_out_o & 6'h28, 6'h08);
  endtask : t_mii_tx
  task automatic t_mii_rx;
    logic [3:0] pat [4] = '{4'h1, 4'h9, 4'h6, 4'h0};
    line_sel_i = 12'h115;
    foreach (pat[i]) begin
      rx_i = {1'b0, pat[i][3], 1'b0, pat[i][2:0]};
      step(4);
      check(6'(fcc_rx_o), 6'(pat[i]));
      check(6'(fcc_broken_hdr_o), 6'(pat[i] == 4'h1));
    end
  endtask : t_mii_rx
  task automatic t_rts;
    int n;
    fcc_mii_mode_i = 1'b0;
    line_sel_i = 12'h010;
    rx_i = 6'h04;
    fcc_rts_req_i = 1'b1;
    step(3);
    check({pin_oe_n_o[2], pin_out_o[2], 3'h0, fcc_rts_granted_o}, 6'h00);
    for (n = 0; n < 20 && fcc_rts_granted_o !== 1'b1; n++) step(1);
    check({5'h00, fcc_rts_granted_o}, 6'h01);
    check(6'(n > 5), 6'h01);
    fcc_rts_req_i = 1'b0;
    step(3);
    check({pin_oe_n_o[2], pin_out_o[2], 3'h0, fcc_rts_granted_o}, 6'h10);
  endtask : t_rts
  task automatic t_scc;
    line_sel_i = 12'ha20;
    rx_i = 6'h20;
    {scc_txd_i, scc_rts_req_i, scc_eth_tx_en_i} = 3'h7;
    for (int e = 0; e < 2; e++) begin
      scc_eth_mode_i = 1'(e);
      step(4);
      check(pin_oe_n_o & 6'h14, 6'h00);
      check(pin_out_o & 6'h14, 6'h10 | 6'(e << 2));
      check(6'(scc_rxd_o), 6'h01);
    end
  endtask : t_scc
  task automatic t_tdm;
    line_sel_i = 12'hffc;
    {tdm_b2_txd_i, tdm_c2_txd_i} = 2'h3;
    rx_i = 6'h14;
    step(4);
    check(pin_out_o & 6'h22, 6'h22);
    check(pin_oe_n_o, 6'h1d);
    check(6'(tdm_b2_rx_o), 6'h05);
  endtask : t_tdm
  // general-purpose lines: outputs driven, inputs read back, peripherals see 0
  task automatic t_gpio;
    line_sel_i = 12'h000;
    gpio_dir_i = 6'h0f;
    gpio_out_i = 6'h05;
    rx_i = 6'h30;
    step(5);
    check(pin_oe_n_o, 6'h30);
    check(pin_out_o & 6'h0f, 6'h05);
    check(gpio_in_o, 6'h35);
    check({2'h0, fcc_rx_o}, 6'h00);
    check({1'b0, scc_rxd_o, fcc_broken_hdr_o, tdm_b2_rx_o}, 6'h00);
  endtask : t_gpio
  initial begin
    rst_i = 1'b1;
    {line_sel_i, fcc_mii_mode_i, scc_eth_mode_i, gpio_out_i, gpio_dir_i} = '0;
    {fcc_tx_i, fcc_rts_req_i, scc_txd_i, scc_rts_req_i, scc_eth_tx_en_i} = '0;
    {tdm_b2_txd_i, tdm_c2_txd_i} = 2'h0;
    rx_i = 6'h04;
    cts_dly_i = 4'h6;
    step(5);
    rst_i = 1'b0;
    step(1);
    check(pin_oe_n_o, PIN_OE_N_RST);
    check(pin_out_o, PIN_OUT_RST);
    t_mii_tx();
    t_mii_rx();
    t_rts();
    t_scc();
    t_tdm();
    t_gpio();
    complete_run();
  end
  // watchdog well past the 69 cycles at most that the scenarios need
  initial begin
    #4000;
    num_errors++;
    complete_run();
  end
endmodule : tb_port_b_upper_pin_function_mux
`default_nettype wire
